// [shared/aam_pkg.sv]
// aam_pkg: constants and types shared by the alarm monitor design files.
// assumes a 125 MHz system clock; no bus, all configuration arrives on plain ports.
package aam_pkg;

  // ----------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------
  localparam int CODE_W = 16;
  localparam int FRAME_W = 32;
  localparam int CNT_W = 6;
  localparam logic [CODE_W-1:0] CODE_MAX = 16'hFFFF;
  localparam logic [CODE_W-1:0] CODE_ZERO = 16'h0000;

  // pin function field of the output control register
  localparam int PINFN_W = 2;
  localparam logic [PINFN_W-1:0] PINFN_ALARM = 2'h1;
  localparam logic [PINFN_W-1:0] PINFN_RESET = 2'h0;

  // received command word forced to no-operation at frame start
  localparam logic [FRAME_W-1:0] CMD_NOP = 32'h0000_0000;

  // alarm flag vector layout: {supply_lo, supply_hi, in_lo, in_hi}
  localparam int FLAG_W = 4;
  localparam int FL_IN_HI = 0;
  localparam int FL_IN_LO = 1;
  localparam int FL_SUP_HI = 2;
  localparam int FL_SUP_LO = 3;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 4'h0;

  // append select width (one enable per flag group: active, tripped)
  localparam int APP_W = 2;

  // supply trip points in millivolts
  localparam int SUP_HI_MV = 5300;
  localparam int SUP_LO_MV = 4700;

  // conversion time handled by the internal clock
  localparam int T_CONV_NS = 640;
  localparam int CLK_NS = 8;
  localparam int CONV_CYC = (T_CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_W = 8;

  // synchroniser reset value
  localparam logic [2:0] SYNC_RESET = 3'h0;

  typedef enum logic [1:0] {AAM_ACQ, AAM_FRAME, AAM_CONV} aam_state_e;

endpackage

// [shared/aam_flag_if.sv]
// aam_flag_if: carries conversion results from the top to the alarm evaluator
// and active/tripped flags back; assumes both ends run on the same clock.
`timescale 1ns/1ns
interface aam_flag_if;
  import aam_pkg::*;
  logic eoc;
  logic [CODE_W-1:0] code;
  logic supply_hi;
  logic supply_lo;
  logic [FLAG_W-1:0] active;
  logic [FLAG_W-1:0] tripped;
  logic clear_tripped;
  modport top (output eoc, code, supply_hi, supply_lo, clear_tripped,
               input active, tripped);
  modport eval (input eoc, code, supply_hi, supply_lo, clear_tripped,
                output active, tripped);
endinterface

// [logic/aam_eval.sv]
// aam_eval: threshold/hysteresis comparison and active/tripped flag storage.
// assumes eoc is a one-cycle pulse on clk and code is stable while it is high.
`timescale 1ns/1ns
module aam_eval
  import aam_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic [CODE_W-1:0] hi_th, // high threshold
  input wire logic [CODE_W-1:0] lo_th, // low threshold
  input wire logic [CODE_W-1:0] hyst, // shared hysteresis
  input wire logic in_dis, // input alarm disable
  input wire logic sup_dis, // supply alarm disable
  aam_flag_if.eval fi // flags to and from top
);

  // ----------------------------------------------------------------
  // saturating arithmetic
  // ----------------------------------------------------------------
  function automatic logic [CODE_W-1:0] sat_sub(input logic [CODE_W-1:0] a,
                                                input logic [CODE_W-1:0] b);
    logic [CODE_W:0] r;
    r = {1'b0, a} - {1'b0, b};
    sat_sub = r[CODE_W] ? CODE_ZERO : r[CODE_W-1:0];
  endfunction

  function automatic logic [CODE_W-1:0] sat_add(input logic [CODE_W-1:0] a,
                                                input logic [CODE_W-1:0] b);
    logic [CODE_W:0] r;
    r = {1'b0, a} + {1'b0, b};
    sat_add = r[CODE_W] ? CODE_MAX : r[CODE_W-1:0];
  endfunction

  logic [FLAG_W-1:0] active_q;
  logic [FLAG_W-1:0] active_d;
  logic [FLAG_W-1:0] tripped_q;
  logic [FLAG_W-1:0] tripped_d;
  logic in_hi_st_q;
  logic in_lo_st_q;

  // ----------------------------------------------------------------
  // hysteresis comparators
  // ----------------------------------------------------------------
  // thresholds saturate so a large hysteresis cannot wrap the release point
  wire logic [CODE_W-1:0] hi_rel = sat_sub(sat_sub(hi_th, hyst), 16'h0001);
  wire logic [CODE_W-1:0] lo_rel = sat_add(sat_add(lo_th, hyst), 16'h0001);
  wire logic hi_set = fi.code > hi_th;
  wire logic hi_clr = fi.code <= hi_rel;
  wire logic lo_set = fi.code < lo_th;
  wire logic lo_clr = fi.code >= lo_rel;
  wire logic hi_next = hi_set | (in_hi_st_q & ~hi_clr);
  wire logic lo_next = lo_set | (in_lo_st_q & ~lo_clr);

  always_comb begin
    active_d = active_q;
    if (fi.eoc) begin
      // active flags are rebuilt from scratch each conversion
      active_d[FL_IN_HI] = hi_next & ~in_dis;
      active_d[FL_IN_LO] = lo_next & ~in_dis;
      active_d[FL_SUP_HI] = fi.supply_hi & ~sup_dis;
      active_d[FL_SUP_LO] = fi.supply_lo & ~sup_dis;
    end
  end

  // a new trip in the same cycle as the read-clear wins
  always_comb begin
    tripped_d = tripped_q & ~{FLAG_W{fi.clear_tripped}};
    if (fi.eoc) begin
      tripped_d = tripped_d | active_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      active_q <= FLAGS_RESET;
      tripped_q <= FLAGS_RESET;
      in_hi_st_q <= 1'b0;
      in_lo_st_q <= 1'b0;
    end else begin
      active_q <= active_d;
      tripped_q <= tripped_d;
      if (fi.eoc) begin
        in_hi_st_q <= hi_next;
        in_lo_st_q <= lo_next;
      end
    end
  end

  assign fi.active = active_q;
  assign fi.tripped = tripped_q;

endmodule // aam_eval

// [logic/aam_top.sv]
// aam_top: digital side of a 16-bit converter with input and supply alarms,
// a 32-bit full-duplex shift port and a multifunction alarm pin.
// assumes convert_select_line, sclk and sdi come from the host's domain.
`timescale 1ns/1ns
module aam_top
  import aam_pkg::*;
(
  input wire logic clk, // 125 MHz system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic convert_select_line, // frame select / convert start, low opens frame
  input wire logic sclk, // host serial clock, mode 0
  input wire logic sdi, // host serial data in
  output logic primary_serial_out, // serial data out
  output logic primary_serial_out_oe, // high while data out is driven
  output logic alarm_multifunction_pin, // alarm level when configured
  output logic ready_indicator, // high when idle in acquisition
  input wire logic [CODE_W-1:0] conv_code, // raw converter result, straight binary
  input wire logic supply_over, // comparator: analog_supply above 5.3 V
  input wire logic supply_under, // comparator: analog_supply below 4.7 V
  input wire logic [PINFN_W-1:0] second_out_pin_function, // output control field
  input wire logic input_alarm_disable, // reset/power control bit
  input wire logic supply_alarm_disable, // reset/power control bit
  input wire logic [CODE_W-1:0] high_threshold, // high threshold register
  input wire logic [CODE_W-1:0] low_threshold, // low threshold register
  input wire logic [CODE_W-1:0] hysteresis, // shared hysteresis
  input wire logic [APP_W-1:0] append_select, // data output control: {tripped, active}
  input wire logic alarm_read, // host reads alarm register, one-cycle pulse
  output logic [FLAG_W-1:0] alarm_active, // alarm register active flags
  output logic [FLAG_W-1:0] alarm_tripped, // alarm register tripped flags
  output logic cmd_valid, // one-cycle pulse with received word
  output logic [FRAME_W-1:0] cmd_word // received command word
);

  aam_flag_if fi ();

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // three stages; a level counts once stages two and three agree
  logic [2:0] cs_sync_q;
  logic [2:0] sck_sync_q;
  logic [2:0] sdi_sync_q;
  logic cs_lvl_q;
  logic sck_lvl_q;

  // select idles high, so its stages reset high to avoid a false frame open
  always_ff @(posedge clk) begin
    if (srst) begin
      cs_sync_q <= 3'h7;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], convert_select_line};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sck_sync_q <= SYNC_RESET;
    end else begin
      sck_sync_q <= {sck_sync_q[1:0], sclk};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sdi_sync_q <= SYNC_RESET;
    end else begin
      sdi_sync_q <= {sdi_sync_q[1:0], sdi};
    end
  end

  wire logic cs_agree = cs_sync_q[1] == cs_sync_q[2];
  wire logic sck_agree = sck_sync_q[1] == sck_sync_q[2];

  always_ff @(posedge clk) begin
    if (srst) begin
      cs_lvl_q <= 1'b1;
    end else if (cs_agree) begin
      cs_lvl_q <= cs_sync_q[2];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sck_lvl_q <= 1'b0;
    end else if (sck_agree) begin
      sck_lvl_q <= sck_sync_q[2];
    end
  end

  wire logic cs_fall = cs_agree & ~cs_sync_q[2] & cs_lvl_q;
  wire logic cs_rise = cs_agree & cs_sync_q[2] & ~cs_lvl_q;
  wire logic sck_rise = sck_agree & sck_sync_q[2] & ~sck_lvl_q;
  wire logic sck_fall = sck_agree & ~sck_sync_q[2] & sck_lvl_q;

  // ----------------------------------------------------------------
  // device state
  // ----------------------------------------------------------------
  aam_state_e state_q;
  aam_state_e state_d;
  logic [CONV_W-1:0] conv_cnt_q;
  logic [CONV_W-1:0] conv_cnt_d;

  wire logic conv_done = (state_q == AAM_CONV) && (conv_cnt_q == CONV_W'(CONV_CYC - 1));

  always_comb begin
    state_d = state_q;
    conv_cnt_d = conv_cnt_q;
    unique case (state_q)
      AAM_ACQ: begin
        if (cs_fall) state_d = AAM_FRAME;
        else if (cs_rise) state_d = AAM_CONV;
        conv_cnt_d = '0;
      end
      AAM_FRAME: begin
        if (cs_rise) state_d = AAM_CONV;
        conv_cnt_d = '0;
      end
      AAM_CONV: begin
        // select edges are ignored until the conversion completes
        conv_cnt_d = conv_cnt_q + CONV_W'(1);
        if (conv_done) state_d = AAM_ACQ;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= AAM_ACQ;
      conv_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      conv_cnt_q <= conv_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // result capture and alarm evaluation
  // ----------------------------------------------------------------
  // the code is taken as unsigned straight binary for every span; range selection
  // lives in the analog front end, so no sign handling exists here
  logic [CODE_W-1:0] result_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      result_q <= CODE_ZERO;
    end else if (conv_done) begin
      result_q <= conv_code;
    end
  end

  assign fi.eoc = conv_done;
  assign fi.code = conv_code;
  assign fi.supply_hi = supply_over;
  assign fi.supply_lo = supply_under;
  assign fi.clear_tripped = alarm_read;

  aam_eval u_eval (
    .clk(clk),
    .srst(srst),
    .hi_th(high_threshold),
    .lo_th(low_threshold),
    .hyst(hysteresis),
    .in_dis(input_alarm_disable),
    .sup_dis(supply_alarm_disable),
    .fi(fi)
  );

  // ----------------------------------------------------------------
  // alarm pin and register view
  // ----------------------------------------------------------------
  wire logic pin_is_alarm = second_out_pin_function == PINFN_ALARM;
  wire logic any_active = |fi.active;
  wire logic pin_d = pin_is_alarm & any_active;
  logic alarm_pin_q;
  logic [FLAG_W-1:0] alarm_active_q;
  logic [FLAG_W-1:0] alarm_tripped_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_pin_q <= 1'b0;
    end else begin
      alarm_pin_q <= pin_d;
    end
  end

  // register view takes the flags at the same edge as the pin, so both agree
  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_active_q <= FLAGS_RESET;
      alarm_tripped_q <= FLAGS_RESET;
    end else begin
      alarm_active_q <= fi.active;
      alarm_tripped_q <= fi.tripped;
    end
  end

  // ----------------------------------------------------------------
  // 32-bit shift register
  // ----------------------------------------------------------------
  // output word: result, then optional flag groups, zero padded
  wire logic [FLAG_W-1:0] app_act = append_select[0] ? fi.active : FLAGS_RESET;
  wire logic [FLAG_W-1:0] app_trp = append_select[1] ? fi.tripped : FLAGS_RESET;
  wire logic [FRAME_W-1:0] out_word = {result_q, app_act, app_trp, 8'h00};

  logic [FRAME_W-1:0] osr_q;
  logic [FRAME_W-1:0] isr_q;
  logic [CNT_W-1:0] bit_cnt_q;
  logic sdo_q;
  logic sdo_oe_q;
  logic cmd_valid_q;
  logic [FRAME_W-1:0] cmd_word_q;
  logic rdy_q;

  wire logic in_frame = state_q == AAM_FRAME;
  wire logic frame_open = (state_q == AAM_ACQ) && cs_fall;
  wire logic frame_close = in_frame && cs_rise;
  wire logic sdo_d = frame_open ? out_word[FRAME_W-1] : osr_q[FRAME_W-1];

  always_ff @(posedge clk) begin
    if (srst) begin
      osr_q <= CMD_NOP;
    end else if (frame_open) begin
      osr_q <= out_word;
    end else if (in_frame && sck_fall) begin
      osr_q <= {osr_q[FRAME_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      isr_q <= CMD_NOP;
      bit_cnt_q <= '0;
    end else if (frame_open) begin
      isr_q <= CMD_NOP;
      bit_cnt_q <= '0;
    end else if (in_frame && sck_rise) begin
      isr_q <= {isr_q[FRAME_W-2:0], sdi_sync_q[2]};
      bit_cnt_q <= bit_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      sdo_q <= sdo_d;
      sdo_oe_q <= state_d == AAM_FRAME;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_valid_q <= 1'b0;
      cmd_word_q <= CMD_NOP;
    end else begin
      cmd_valid_q <= frame_close;
      if (frame_close) cmd_word_q <= isr_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdy_q <= 1'b1;
    end else begin
      rdy_q <= state_d == AAM_ACQ;
    end
  end

  // only the hold between edges differs: sdo tracks osr MSB, which moves on sclk fall
  assign primary_serial_out = sdo_q;
  assign primary_serial_out_oe = sdo_oe_q;
  assign alarm_multifunction_pin = alarm_pin_q;
  assign ready_indicator = rdy_q;
  assign alarm_active = alarm_active_q;
  assign alarm_tripped = alarm_tripped_q;
  assign cmd_valid = cmd_valid_q;
  assign cmd_word = cmd_word_q;

endmodule // aam_top

// [dv/aam_top_asserts.sv]
// aam_top_asserts: timing relations between the alarm monitor's top ports.
// assumes one clk domain with srst synchronous active high; bound from the bench.
`timescale 1ns/1ns
module aam_top_asserts
  import aam_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic convert_select_line, // frame select pin
  input wire logic primary_serial_out_oe, // data out enable
  input wire logic alarm_multifunction_pin, // alarm pin
  input wire logic [PINFN_W-1:0] second_out_pin_function, // pin function field
  input wire logic ready_indicator, // idle in acquisition
  input wire logic alarm_read, // tripped clear pulse
  input wire logic [FLAG_W-1:0] alarm_active, // active flags
  input wire logic [FLAG_W-1:0] alarm_tripped, // tripped flags
  input wire logic cmd_valid // received word pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // flags and pin
  // ----------------------------------------------------------------
  // pin and flags are registered at the same edge; this check still judges only a flag vector settled for two cycles
  property p_pin_src;
    alarm_multifunction_pin && alarm_active == $past(alarm_active)
      && alarm_active == $past(alarm_active, 2) |-> |alarm_active;
  endproperty
  a_pin_src: assert property (p_pin_src) else $error("alarm pin high, no flag");
  // pin and flag view leave the evaluator at the same edge; the field is one cycle older
  property p_pin_fn;
    alarm_multifunction_pin
      == (($past(second_out_pin_function) == PINFN_ALARM) && (|alarm_active));
  endproperty
  a_pin_fn: assert property (p_pin_fn) else $error("alarm pin level off");
  property p_trip_set;
    ((alarm_active & ~$past(alarm_active)) & ~alarm_tripped) == 4'h0;
  endproperty
  a_trip_set: assert property (p_trip_set) else $error("active set, tripped not");
  property p_trip_hold;
    (~alarm_tripped & $past(alarm_tripped)) != 4'h0 |-> $past(alarm_read)
      || $past(alarm_read, 2);
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("tripped fell, no read");
  property p_flag_eoc;
    $changed(alarm_active) |-> !$past(ready_indicator, 2);
  endproperty
  a_flag_eoc: assert property (p_flag_eoc) else $error("flags moved in idle");
  // ----------------------------------------------------------------
  // frame
  // ----------------------------------------------------------------
  property p_oe_ready;
    primary_serial_out_oe |-> !ready_indicator;
  endproperty
  a_oe_ready: assert property (p_oe_ready) else $error("ready high in frame");
  property p_oe_open;
    $rose(primary_serial_out_oe) |-> !convert_select_line && !$past(convert_select_line, 2);
  endproperty
  a_oe_open: assert property (p_oe_open) else $error("frame open, select high");
  property p_cmd_after;
    $rose(convert_select_line) && primary_serial_out_oe |-> ##[2:6] cmd_valid;
  endproperty
  a_cmd_after: assert property (p_cmd_after) else $error("no word after frame");
  property p_oe_close;
    $rose(convert_select_line) && primary_serial_out_oe |-> ##[2:6] !primary_serial_out_oe;
  endproperty
  a_oe_close: assert property (p_oe_close) else $error("out not released");
  property p_cmd_pulse;
    cmd_valid |-> convert_select_line ##1 !cmd_valid;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("word pulse too long");
  property p_conv_time;
    cmd_valid |=> !ready_indicator [*8] ##[60:100] ready_indicator;
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion length off");
endmodule // aam_top_asserts

// [dv/aam_host.sv]
// aam_host: behavioural host driving mode 0 frames of 32 bits into the monitor.
// assumes clk paces it; one sclk period is ten clk cycles, sclk idle low.
`timescale 1ns/1ns
module aam_host (
  input wire logic clk, // time base
  output logic sel_n, // frame select, low in frame
  output logic sclk, // serial clock
  output logic sdi, // data to device
  input wire logic sdo // data from device
);
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    sel_n = 1'b0;
    tick(8);
    for (int i = 31; i >= 0; i--) begin
      sdi = tx[i];
      tick(5);
      rx[i] = sdo;
      sclk = 1'b1;
      tick(5);
      sclk = 1'b0;
    end
    tick(5);
    sel_n = 1'b1;
    // released line must not keep the last bit
    sdi = ~sdi;
  endtask
endmodule // aam_host

// [dv/tb_aam_top.sv]
// tb_aam_top: self-checking bench for the alarm monitor: frames, thresholds, flags.
// assumes aam_host drives the serial pins; all other inputs are driven here.
`timescale 1ns/1ns
module tb_aam_top;
  import aam_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sel_n, sclk, sdi, sdo, oe, pin, rdy, cv;
  logic ov = 1'b0, un = 1'b0, id = 1'b0, sd = 1'b0, rd = 1'b0, hs = 1'b0, ls = 1'b0;
  logic [1:0] fn = 2'h1, ap = 2'h0;
  logic [15:0] code = 16'h0000, hi = 16'h03E8, lo = 16'h00C8, hy = 16'h000A, lc = 16'h0000;
  logic [3:0] act, trp, ea = 4'h0, et = 4'h0;
  logic [31:0] cw, rx, ew;
  int failures = 0, tests_run = 0;
  always #4 clk = ~clk;
  aam_host aam_host_i (.clk(clk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
  aam_top aam_top_i (.clk(clk), .srst(srst), .convert_select_line(sel_n), .sclk(sclk),
    .sdi(sdi), .primary_serial_out(sdo), .primary_serial_out_oe(oe),
    .alarm_multifunction_pin(pin), .ready_indicator(rdy), .conv_code(code),
    .supply_over(ov), .supply_under(un), .second_out_pin_function(fn),
    .input_alarm_disable(id), .supply_alarm_disable(sd), .high_threshold(hi),
    .low_threshold(lo), .hysteresis(hy), .append_select(ap), .alarm_read(rd),
    .alarm_active(act), .alarm_tripped(trp), .cmd_valid(cv), .cmd_word(cw));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic results;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic wait_hi(input bit use_rdy);
    int n;
    n = 0;
    while ((use_rdy ? rdy : cv) !== 1'b1) begin
      tick(1);
      n++;
      if (n > 200) begin
        failures++;
        $display("BAD t=%0t wait expired", $time);
        results();
      end
    end
  endtask
  // release points saturate at the ends of the code range
  function automatic logic hi_nx(logic [15:0] c, logic [15:0] t, logic [15:0] h, logic s);
    logic [16:0] r;
    r = (t > h) ? {1'b0, t} - h - 17'h1 : 17'h0;
    return (c > t) ? 1'b1 : ({1'b0, c} <= r) ? 1'b0 : s;
  endfunction
  function automatic logic lo_nx(logic [15:0] c, logic [15:0] t, logic [15:0] h, logic s);
    logic [16:0] r;
    r = {1'b0, t} + h + 17'h1;
    if (r > 17'h0FFFF) r = 17'h0FFFF;
    return (c < t) ? 1'b1 : ({1'b0, c} >= r) ? 1'b0 : s;
  endfunction
  task automatic conv(input logic [15:0] c, input logic o, input logic u);
    logic [31:0] tx;
    tx = $urandom();
    ew = {lc, ap[0] ? ea : 4'h0, ap[1] ? et : 4'h0, 8'h00};
    code = c;
    ov = o;
    un = u;
    aam_host_i.frame(tx, rx);
    chk(rx[31:16], lc, "result");
    chk(rx, ew, "out word");
    wait_hi(1'b0);
    chk(cw, tx, "cmd word");
    wait_hi(1'b1);
    hs = hi_nx(c, hi, hy, hs);
    ls = lo_nx(c, lo, hy, ls);
    ea = {u & ~sd, o & ~sd, ls & ~id, hs & ~id};
    et = et | ea;
    lc = c;
    tick(2);
    chk(act, ea, "active");
    chk(trp, et, "tripped");
    chk(pin, fn == PINFN_ALARM && |ea, "pin");
  endtask
  task automatic rd_flags;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(3);
    et = 4'h0;
    chk(trp, et, "read clear");
    chk(act, ea, "active kept");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] cc [10];
    logic [15:0] c;
    int i;
    cc = '{16'h03E9, 16'h03DE, 16'h03DD, 16'h03E8, 16'h00C7, 16'h00D2, 16'h00D3,
      16'hFFFF, 16'h0001, 16'h0000};
    void'($urandom(62225));
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
    tick(4);
    chk({act, trp, pin, rdy, oe, cv}, {8'h00, 4'h4}, "reset");
    for (i = 0; i < 10; i++) begin
      if (i == 7) hy = 16'hFFFF;
      conv(cc[i], i == 7, i == 8);
    end
    rd_flags();
    $display("corner cases done");
    for (i = 0; i < 30; i++) begin
      hy = 16'($urandom_range(0, 31));
      hi = 16'($urandom_range(1000, 60000));
      lo = 16'($urandom_range(100, 900));
      fn = 2'($urandom_range(0, 3));
      ap = 2'($urandom_range(0, 3));
      id = ($urandom_range(0, 3) == 0);
      sd = ($urandom_range(0, 3) == 0);
      c = 16'(($urandom_range(0, 1) ? hi : lo) + $urandom_range(0, 80) - 40);
      conv(c, $urandom_range(0, 3) == 0, $urandom_range(0, 3) == 0);
      if (i % 4 == 3) rd_flags();
    end
    $display("random cases done");
    results();
  end
endmodule // tb_aam_top
bind aam_top aam_top_asserts aam_top_asserts_i (.clk(clk), .srst(srst),
  .convert_select_line(convert_select_line), .primary_serial_out_oe(primary_serial_out_oe),
  .alarm_multifunction_pin(alarm_multifunction_pin),
  .second_out_pin_function(second_out_pin_function), .ready_indicator(ready_indicator),
  .alarm_read(alarm_read), .alarm_active(alarm_active), .alarm_tripped(alarm_tripped),
  .cmd_valid(cmd_valid));
